// ---- ccd_pkg.sv ----
// Constants and types shared by the cascaded channel divider
package ccd_pkg;
	localparam int CCD_STAGES = 2;
	localparam int CCD_FIELD_W = 4;
	localparam int CCD_RATIO_W = 11;
	localparam int CCD_ADDR_W = 4;
	// Register byte offsets on the Avalon-MM slave
	localparam logic [3:0] CCD_OFS_CTRL = 4'h0;
	localparam logic [3:0] CCD_OFS_DIV1 = 4'h4;
	localparam logic [3:0] CCD_OFS_DIV2 = 4'h8;
	localparam logic [3:0] CCD_OFS_STATUS = 4'hC;
	// Control register bit positions
	localparam int CCD_CTRL_BYP1 = 0;
	localparam int CCD_CTRL_BYP2 = 1;
	localparam int CCD_CTRL_DCC_DIS = 2;
	// Divider register fields: high count in [3:0], low count in [7:4]
	localparam int CCD_DIV_HIGH_LSB = 0;
	localparam int CCD_DIV_LOW_LSB = 4;
	// Status register: ratio in [10:0], channel output level in [16]
	localparam int CCD_STAT_OUT_BIT = 16;
	// Reset values and the channel ratio limit
	localparam logic [2:0] CCD_CTRL_RESET = 3'h0;
	localparam logic [7:0] CCD_DIV_RESET = 8'h00;
	localparam logic [CCD_RATIO_W-1:0] CCD_RATIO_MAX = 11'h400;

	// Per-stage divide setting
	typedef struct packed {
		logic [CCD_FIELD_W-1:0] low_cnt;
		logic [CCD_FIELD_W-1:0] high_cnt;
	} ccd_div_t;

	// Whole block state, registered as one word
	typedef struct packed {
		logic byp1;
		logic byp2;
		logic duty_correction_disable;
		ccd_div_t [CCD_STAGES-1:0] div;
		logic [CCD_STAGES-1:0] prev_in;
		logic [CCD_STAGES-1:0] phase;
		logic [CCD_STAGES-1:0] pend;
		logic [CCD_STAGES-1:0] out;
		logic [CCD_STAGES-1:0][CCD_FIELD_W-1:0] cnt;
		logic ack;
		logic [31:0] rdata;
	} ccd_state_t;
endpackage : ccd_pkg

// ---- ccd_divider.sv ----
// Two-stage cascaded channel divider with duty-cycle correction and Avalon-MM slave
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ccd_divider
	import ccd_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic div_clk_in,
	input wire logic [CCD_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic chan_clk_out,
	output logic [CCD_RATIO_W-1:0] ratio_out
);
	ccd_state_t st;
	ccd_state_t next_st;
	logic [CCD_STAGES-1:0] stage_in;
	logic [CCD_STAGES-1:0] stage_byp;
	logic [CCD_STAGES-1:0] rise;
	logic [CCD_STAGES-1:0] fall;
	logic [CCD_STAGES-1:0] odd;
	logic [CCD_STAGES-1:0][5:0] stage_ratio;
	logic [CCD_RATIO_W-1:0] ratio;
	logic stage1_eff;
	logic req;

	// Stage inputs: stage two sees the input clock when stage one is bypassed
	assign stage_byp = {st.byp2, st.byp1};
	assign stage1_eff = st.byp1 ? div_clk_in : st.out[0];
	assign stage_in = {stage1_eff, div_clk_in};
	assign rise = stage_in & ~st.prev_in;
	assign fall = ~stage_in & st.prev_in;

	// Per-stage ratio and parity, bypass counts as one
	genvar g;
	generate
		for (g = 0; g < CCD_STAGES; g++) begin : g_ratio
			assign stage_ratio[g] = stage_byp[g] ? 6'h01 :
				6'(st.div[g].high_cnt) + 6'(st.div[g].low_cnt) + 6'h02;
			assign odd[g] = stage_ratio[g][0];
		end
	endgenerate

	// Product of both stage ratios, at most 32 x 32 = 1024
	assign ratio = CCD_RATIO_W'(stage_ratio[0] * stage_ratio[1]);
	assign ratio_out = ratio;

	// Channel output: a bypassed second stage forwards the first stage result
	assign chan_clk_out = st.byp2 ? stage1_eff : st.out[1];

	// Slave stalls one cycle per request so read data comes from a flop
	assign req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~st.ack;
	assign avs_readdata_out = st.rdata;

	// Next-state logic for stages and the register file
	always_comb begin
		next_st = st;
		next_st.prev_in = stage_in;
		for (int i = 0; i < CCD_STAGES; i++) begin
			// Counting only on input rises keeps each stage on its own input clock
			if (rise[i]) begin
				if (st.phase[i]) begin
					if (st.cnt[i] == st.div[i].high_cnt) begin
						next_st.phase[i] = 1'b0;
						next_st.cnt[i] = '0;
						// Odd ratio: hold high to the next input fall, half a cycle more
						next_st.pend[i] = odd[i] & ~st.duty_correction_disable;
					end else begin
						next_st.cnt[i] = st.cnt[i] + 4'h1;
					end
				end else begin
					if (st.cnt[i] == st.div[i].low_cnt) begin
						next_st.phase[i] = 1'b1;
						next_st.cnt[i] = '0;
					end else begin
						next_st.cnt[i] = st.cnt[i] + 4'h1;
					end
				end
			end
			if (fall[i]) begin
				next_st.pend[i] = 1'b0;
			end
			// Bypassed stage restarts in its high phase when brought back
			if (stage_byp[i]) begin
				next_st.phase[i] = 1'b1;
				next_st.pend[i] = 1'b0;
				next_st.cnt[i] = '0;
			end
			next_st.out[i] = next_st.phase[i] | next_st.pend[i];
		end
		// Bus: first cycle loads read data, second cycle completes
		next_st.ack = req & ~st.ack;
		if (req & ~st.ack) begin
			case (avs_address_in)
				CCD_OFS_CTRL: next_st.rdata = {29'h0, st.duty_correction_disable, st.byp2, st.byp1};
				CCD_OFS_DIV1: next_st.rdata = {24'h0, st.div[0]};
				CCD_OFS_DIV2: next_st.rdata = {24'h0, st.div[1]};
				CCD_OFS_STATUS: next_st.rdata = {15'h0, chan_clk_out, 5'h0, ratio};
				default: next_st.rdata = 32'h0;
			endcase
		end
		// Writes land on the edge where waitrequest is low; only byte lane 0 is used
		if (avs_write_in & st.ack & avs_byteenable_in[0]) begin
			case (avs_address_in)
				CCD_OFS_CTRL: begin
					next_st.byp1 = avs_writedata_in[CCD_CTRL_BYP1];
					next_st.byp2 = avs_writedata_in[CCD_CTRL_BYP2];
					next_st.duty_correction_disable = avs_writedata_in[CCD_CTRL_DCC_DIS];
				end
				CCD_OFS_DIV1: next_st.div[0] = avs_writedata_in[7:0];
				CCD_OFS_DIV2: next_st.div[1] = avs_writedata_in[7:0];
				default: next_st.rdata = st.rdata;
			endcase
		end
	end

	// State register; correction enabled and stages high-first after reset
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			st.byp1 <= CCD_CTRL_RESET[CCD_CTRL_BYP1];
			st.byp2 <= CCD_CTRL_RESET[CCD_CTRL_BYP2];
			st.duty_correction_disable <= CCD_CTRL_RESET[CCD_CTRL_DCC_DIS];
			st.div <= {CCD_DIV_RESET, CCD_DIV_RESET};
			st.prev_in <= '0;
			st.phase <= '1;
			st.pend <= '0;
			st.out <= '1;
			st.cnt <= '0;
			st.ack <= 1'b0;
			st.rdata <= 32'h0;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_high_done(int i);
		rise[i] && st.phase[i] && !stage_byp[i] && st.cnt[i] == st.div[i].high_cnt;
	endsequence

	AST_BYPASS_PASS: assert property (st.byp1 && st.byp2 |-> chan_clk_out == div_clk_in)
		else $error("bypassed channel does not pass input clock");
	AST_HIGH_END: assert property (s_high_done(0) |=> !st.phase[0])
		else $error("stage one high phase wrong length");
	AST_LOW_END: assert property (rise[0] && !st.phase[0] && !st.byp1
		&& st.cnt[0] == st.div[0].low_cnt |=> st.phase[0])
		else $error("stage one low phase wrong length");
	AST_CNT_HOLD: assert property (!rise[1] && !st.byp2 |=> $stable(st.cnt[1]))
		else $error("stage two counted without input rise");
	AST_DCC_EXTEND: assert property (s_high_done(0) and (odd[0] && !st.duty_correction_disable)
		|=> st.out[0] && !st.phase[0])
		else $error("odd stage not extended by correction");
	AST_DCC_OFF: assert property (st.duty_correction_disable and s_high_done(0)
		|=> !st.out[0])
		else $error("correction active while disabled");
	AST_PEND_CLEAR: assert property (st.pend[0] && fall[0] && !rise[0] |=> !st.pend[0])
		else $error("extension not ended by input fall");
	AST_RATIO_RANGE: assert property (ratio <= CCD_RATIO_MAX && ratio != 11'h0)
		else $error("channel ratio out of range");
	AST_RATIO_ONE: assert property (st.byp1 && st.byp2 |-> ratio == 11'h1)
		else $error("bypassed ratio not one");
	AST_WAIT: assert property (req && !st.ack |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("slave answer not after one wait cycle");
endmodule : ccd_divider

// ---- ccd_src_model.sv ----
// Clock source model feeding the channel divider input
`timescale 1ns/1ps
module ccd_src_model (
	input wire logic core_clk_in,
	input wire logic [3:0] hi_len_in,
	input wire logic [3:0] lo_len_in,
	output logic div_clk_out
);
	logic [3:0] cnt = 4'h0;
	logic lvl = 1'b0;
	assign div_clk_out = lvl;
	// Free running; lengths of two or more keep each level visible to core sampling
	always @(posedge core_clk_in) begin
		if (cnt + 4'h1 >= (lvl ? hi_len_in : lo_len_in)) begin
			cnt <= 4'h0;
			lvl <= ~lvl;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : ccd_src_model

// ---- tb.sv ----
// Self-checking bench for the cascaded channel divider
`timescale 1ns/1ps
module tb;
	import ccd_pkg::*;
	logic core_clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, wait_req, chan_clk, div_clk;
	logic [3:0] addr = 4'h0, hi_len = 4'h4, lo_len = 4'h4;
	logic [31:0] wdata = 32'h0, rdata;
	logic [CCD_RATIO_W-1:0] ratio;
	logic [31:0] expq[$];
	int miscompares = 0, samples_checked = 0, seed = 32'h1602, a, b, c, d;
	initial forever #20 core_clk = ~core_clk;
	ccd_src_model src (.core_clk_in(core_clk), .hi_len_in(hi_len), .lo_len_in(lo_len),
		.div_clk_out(div_clk));
	ccd_divider uut (.core_clk_in(core_clk), .reset_n_in(reset_n), .div_clk_in(div_clk),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
		.chan_clk_out(chan_clk), .ratio_out(ratio));
	task automatic conclude();
		if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// One Avalon access; for reads the data word is the expected value
	task automatic bus(input logic w, input logic [3:0] a_in, input logic [31:0] d_in);
		int n;
		@(posedge core_clk);
		if (!w) expq.push_back(d_in);
		addr <= a_in;
		wr <= w;
		rd <= !w;
		wdata <= d_in;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			conclude();
		end
		@(negedge core_clk);
	endtask : bus
	// Read data checked at the accepting edge, oldest note first
	always @(posedge core_clk) begin
		if (rd && wait_req === 1'b0 && expq.size() > 0) cmp(rdata, expq.pop_front());
	end
	task automatic span(input logic v, output int n);
		n = 0;
		while (chan_clk === v) begin
			@(posedge core_clk);
			n++;
			if (n > 3000) begin
				miscompares++;
				conclude();
			end
		end
	endtask : span
	// Skips a settling period, then measures one high and one low phase
	task automatic meas(input int h, input int l);
		int n;
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, n);
		cmp(32'(n), 32'(h));
		span(1'b0, n);
		cmp(32'(n), 32'(l));
	endtask : meas
	initial begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		cmp(32'(ratio), 32'h4);
		bus(1'b0, CCD_OFS_CTRL, 32'h0);
		bus(1'b1, CCD_OFS_DIV1, 32'h21);
		bus(1'b1, CCD_OFS_CTRL, 32'h6);
		cmp(32'(ratio), 32'h5);
		meas(16, 24);
		bus(1'b1, CCD_OFS_CTRL, 32'h2);
		meas(20, 20);
		bus(1'b1, CCD_OFS_DIV1, 32'h0);
		bus(1'b1, CCD_OFS_DIV2, 32'h10);
		bus(1'b1, CCD_OFS_CTRL, 32'h4);
		cmp(32'(ratio), 32'h6);
		meas(16, 32);
		// Odd first stage, even second stage, correction on
		bus(1'b1, CCD_OFS_DIV1, 32'h21);
		bus(1'b1, CCD_OFS_DIV2, 32'h0);
		bus(1'b1, CCD_OFS_CTRL, 32'h0);
		cmp(32'(ratio), 32'hA);
		meas(40, 40);
		hi_len <= 4'h3;
		lo_len <= 4'h5;
		bus(1'b1, CCD_OFS_CTRL, 32'h7);
		cmp(32'(ratio), 32'h1);
		meas(3, 5);
		bus(1'b1, 4'h2, 32'hFF);
		bus(1'b0, 4'h2, 32'h0);
		bus(1'b1, CCD_OFS_DIV1, 32'hFF);
		bus(1'b1, CCD_OFS_DIV2, 32'hFF);
		bus(1'b1, CCD_OFS_CTRL, 32'h0);
		cmp(32'(ratio), 32'h400);
		// Random fields across both stages
		for (int i = 0; i < 4; i++) begin
			a = $random(seed) & 15;
			b = $random(seed) & 15;
			c = $random(seed) & 15;
			d = $random(seed) & 15;
			bus(1'b1, CCD_OFS_DIV1, 32'((b << 4) | a));
			bus(1'b1, CCD_OFS_DIV2, 32'((d << 4) | c));
			cmp(32'(ratio), 32'((a + b + 2) * (c + d + 2)));
			bus(1'b0, CCD_OFS_DIV1, 32'((b << 4) | a));
		end
		conclude();
	end
endmodule : tb
